// ===== design/dcfpc_map.svh
`ifndef DCFPC_MAP_SVH
`define DCFPC_MAP_SVH

// Offset register (X) width and preset values
`define DCFPC_X_W       7
`define DCFPC_X_RST     7'h04
`define DCFPC_X_SEL_HH  7'h10
`define DCFPC_X_SEL_HL  7'h0c
`define DCFPC_X_SEL_LH  7'h08
`define DCFPC_X_SEL_LL  7'h04

// Threshold select codes {thresh_sel_1, thresh_sel_0}
`define DCFPC_SEL_HH    2'h3
`define DCFPC_SEL_HL    2'h2
`define DCFPC_SEL_LH    2'h1

// Reset values of flags and pin samples, and the pointer step
`define DCFPC_FLAG_LOW  1'h0
`define DCFPC_FLAG_HIGH 1'h1
`define DCFPC_PIN_IDLE  1'h0
`define DCFPC_CS_IDLE   1'h1
`define DCFPC_PTR_STEP  1'h1

`endif

// ===== design/dcfpc_pkg.sv
package dcfpc_pkg;

  // Per-port control pins
  typedef struct packed {
    logic chip_sel_n;
    logic write_read;
    logic xfer_gate;
    logic mail_select;
  } dcfpc_ctrl_t;

  // All single-bit device pins, sampled together
  typedef struct packed {
    logic        port_a_clock;
    logic        port_b_clock;
    logic        reset_n;
    logic        thresh_sel_1;
    logic        thresh_sel_0;
    dcfpc_ctrl_t port_a_ctrl;
    dcfpc_ctrl_t port_b_ctrl;
  } dcfpc_pins_t;

endpackage : dcfpc_pkg

// ===== design/dcfpc_mem.sv
`timescale 1ns/100ps
`include "dcfpc_map.svh"

module dcfpc_mem #(
  parameter int WIDTH = 36,
  parameter int AW    = 6
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  // Write side
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // Read side, data held in the output register
  input  wire logic             rd_en,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] store [0:(1<<AW)-1];

  // Array itself needs no reset; pointers guard every read
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      store[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= store[rd_addr];
    end
  end

endmodule : dcfpc_mem

// ===== design/dcfpc_top.sv
`timescale 1ns/100ps
`include "dcfpc_map.svh"

//Function
// - Reset pin low four edges each port
// - Reset pin accepted at any time
// - Reset clears pointers, flags to reset values
// - Reset drives both mail flags high
// - Full flag high on second port-A edge
// - Reset release loads offset from selects
// - Port A bus driven on select, read
// - Port B bus driven on select, read
// - Port A FIFO write decode and gating
// - Port B FIFO read decode and gating
// - Gate low means no port operation
// - Port A mail read releases its flag
// - Port B mail read releases its flag
// - FIFO status flags pass two port-clock stages
// - Empty blocks reads, read pointer holds
// - Read pointer steps per word read
// - Written word readable third port-B cycle
// - Same-cycle write syncs from next edge
// - Full blocks writes, write pointer holds
// - Write pointer steps per word written
// - Freed location writable third port-A cycle
// - Almost-empty low at offset or fewer
// - Almost-full low at depth minus offset
// - Mail write lowers flag, blocks rewrites
// - Port B bus muxes FIFO or mail
module dcfpc_top #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   sys_rst,
  // Device control pins
  input  wire logic                   port_a_clock,
  input  wire logic                   port_b_clock,
  input  wire logic                   reset_n,
  input  wire logic                   thresh_sel_0,
  input  wire logic                   thresh_sel_1,
  input  wire dcfpc_pkg::dcfpc_ctrl_t port_a_ctrl,
  input  wire dcfpc_pkg::dcfpc_ctrl_t port_b_ctrl,
  // Port A data pins
  input  wire logic [WIDTH-1:0]       port_a_data_in,
  output logic      [WIDTH-1:0]       port_a_data_out,
  output logic                        port_a_data_oe,
  // Port B data pins
  input  wire logic [WIDTH-1:0]       port_b_data_in,
  output logic      [WIDTH-1:0]       port_b_data_out,
  output logic                        port_b_data_oe,
  // Status flags
  output logic                        full_flag_n,
  output logic                        almost_full_flag_n,
  output logic                        empty_flag_n,
  output logic                        almost_empty_flag_n,
  output logic                        mail_ab_flag_n,
  output logic                        mail_ba_flag_n
);

  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  // Pin sampling
  dcfpc_pkg::dcfpc_pins_t pins_raw;
  dcfpc_pkg::dcfpc_pins_t pins_s1;
  dcfpc_pkg::dcfpc_pins_t pins_s2;
  dcfpc_pkg::dcfpc_pins_t pins_d;
  logic [WIDTH-1:0]       data_a_s1;
  logic [WIDTH-1:0]       data_a_s2;
  logic [WIDTH-1:0]       data_b_s1;
  logic [WIDTH-1:0]       data_b_s2;

  // Decode
  dcfpc_pkg::dcfpc_ctrl_t ca;
  dcfpc_pkg::dcfpc_ctrl_t cb;
  logic                   a_rise;
  logic                   b_rise;
  logic                   rst_rise;
  logic                   dev_rst;
  logic                   a_sel;
  logic                   b_sel;
  logic                   fifo_wr;
  logic                   fifo_rd;
  logic                   mail_ab_wr;
  logic                   mail_ab_rd;
  logic                   mail_ba_wr;
  logic                   mail_ba_rd;

  // FIFO state
  logic [AW:0]            wptr;
  logic [AW:0]            rptr;
  logic [AW:0]            next_wptr;
  logic [AW:0]            next_rptr;
  logic [AW:0]            wptr_seen_b;
  logic [AW:0]            rptr_seen_a;
  logic [AW:0]            fill_a;
  logic [AW:0]            fill_b;
  logic                   a_armed;
  logic [`DCFPC_X_W-1:0]  offset_x;
  logic [`DCFPC_X_W-1:0]  next_offset_x;
  logic [WIDTH-1:0]       fifo_q;

  // Mail registers
  logic [WIDTH-1:0]       mail_ab;
  logic [WIDTH-1:0]       mail_ba;

  assign pins_raw.port_a_clock = port_a_clock;
  assign pins_raw.port_b_clock = port_b_clock;
  assign pins_raw.reset_n      = reset_n;
  assign pins_raw.thresh_sel_1 = thresh_sel_1;
  assign pins_raw.thresh_sel_0 = thresh_sel_0;
  assign pins_raw.port_a_ctrl  = port_a_ctrl;
  assign pins_raw.port_b_ctrl  = port_b_ctrl;

  // Every pin, port clocks included, crosses two flops before use
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pins_s1 <= '0;
      pins_s2 <= '0;
      pins_d  <= '0;
      // Selects start deselected, else the buses drive just after reset
      pins_s1.port_a_ctrl.chip_sel_n <= `DCFPC_CS_IDLE;
      pins_s1.port_b_ctrl.chip_sel_n <= `DCFPC_CS_IDLE;
      pins_s2.port_a_ctrl.chip_sel_n <= `DCFPC_CS_IDLE;
      pins_s2.port_b_ctrl.chip_sel_n <= `DCFPC_CS_IDLE;
    end else begin
      pins_s1 <= pins_raw;
      pins_s2 <= pins_s1;
      pins_d  <= pins_s2;
    end
  end

  // Data travels with the same latency as its clock pin
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      data_a_s1 <= '0;
      data_a_s2 <= '0;
      data_b_s1 <= '0;
      data_b_s2 <= '0;
    end else begin
      data_a_s1 <= port_a_data_in;
      data_a_s2 <= data_a_s1;
      data_b_s1 <= port_b_data_in;
      data_b_s2 <= data_b_s1;
    end
  end

  assign ca       = pins_s2.port_a_ctrl;
  assign cb       = pins_s2.port_b_ctrl;
  assign a_rise   = pins_s2.port_a_clock & ~pins_d.port_a_clock;
  assign b_rise   = pins_s2.port_b_clock & ~pins_d.port_b_clock;
  // Level-sensitive, so a pin reset of any phase is honoured
  assign dev_rst  = sys_rst | ~pins_s2.reset_n;
  assign rst_rise = pins_s2.reset_n & ~pins_d.reset_n;

  // No FIFO or mail operation happens on a port unless its gate is high at the edge
  assign a_sel = a_rise & ~ca.chip_sel_n & ca.xfer_gate;
  assign b_sel = b_rise & ~cb.chip_sel_n & cb.xfer_gate;

  // Port A: FIFO write, mail A-to-B write, mail B-to-A read
  assign fifo_wr    = a_sel & ca.write_read & ~ca.mail_select & full_flag_n;
  assign mail_ab_wr = a_sel & ca.write_read & ca.mail_select & mail_ab_flag_n;
  assign mail_ba_rd = a_sel & ~ca.write_read & ca.mail_select;

  // Port B: FIFO read, mail B-to-A write, mail A-to-B read
  assign fifo_rd    = b_sel & ~cb.write_read & ~cb.mail_select & empty_flag_n;
  assign mail_ba_wr = b_sel & cb.write_read & cb.mail_select & mail_ba_flag_n;
  assign mail_ab_rd = b_sel & ~cb.write_read & cb.mail_select;
  // Port A FIFO read and port B FIFO write decode to nothing

  assign next_wptr = fifo_wr ? wptr + (AW+1)'(`DCFPC_PTR_STEP) : wptr;
  assign next_rptr = fifo_rd ? rptr + (AW+1)'(`DCFPC_PTR_STEP) : rptr;

  // Pointers carry one wrap bit so full and empty differ
  always_ff @(posedge ref_clk) begin
    if (dev_rst) begin
      wptr <= '0;
    end else begin
      wptr <= next_wptr;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (dev_rst) begin
      rptr <= '0;
    end else begin
      rptr <= next_rptr;
    end
  end

  // Offset register survives a pin reset; only its release reloads it
  always_comb begin
    unique case ({pins_s2.thresh_sel_1, pins_s2.thresh_sel_0})
      `DCFPC_SEL_HH: next_offset_x = `DCFPC_X_SEL_HH;
      `DCFPC_SEL_HL: next_offset_x = `DCFPC_X_SEL_HL;
      `DCFPC_SEL_LH: next_offset_x = `DCFPC_X_SEL_LH;
      default:       next_offset_x = `DCFPC_X_SEL_LL;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      offset_x <= `DCFPC_X_RST;
    end else if (rst_rise) begin
      offset_x <= next_offset_x;
    end
  end

  // Write pointer seen by port B: first of two port-B stages.
  // A write in the same ref cycle as a port-B edge is caught one edge later.
  always_ff @(posedge ref_clk) begin
    if (dev_rst) begin
      wptr_seen_b <= '0;
    end else if (b_rise) begin
      wptr_seen_b <= wptr;
    end
  end

  assign fill_b = wptr_seen_b - next_rptr;

  // Second port-B stage: empty and almost-empty
  always_ff @(posedge ref_clk) begin
    if (dev_rst) begin
      empty_flag_n <= `DCFPC_FLAG_LOW;
    end else if (b_rise) begin
      empty_flag_n <= (fill_b != '0);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (dev_rst) begin
      almost_empty_flag_n <= `DCFPC_FLAG_LOW;
    end else if (b_rise) begin
      almost_empty_flag_n <= (fill_b > offset_x);
    end
  end

  // Read pointer seen by port A: first of two port-A stages
  always_ff @(posedge ref_clk) begin
    if (dev_rst) begin
      rptr_seen_a <= '0;
    end else if (a_rise) begin
      rptr_seen_a <= rptr;
    end
  end

  // Holds the full flag low until the second port-A edge after reset
  always_ff @(posedge ref_clk) begin
    if (dev_rst) begin
      a_armed <= `DCFPC_FLAG_LOW;
    end else if (a_rise) begin
      a_armed <= `DCFPC_FLAG_HIGH;
    end
  end

  assign fill_a = next_wptr - rptr_seen_a;

  // Second port-A stage: full and almost-full
  always_ff @(posedge ref_clk) begin
    if (dev_rst) begin
      full_flag_n <= `DCFPC_FLAG_LOW;
    end else if (a_rise) begin
      full_flag_n <= a_armed & (fill_a != FULL_CNT);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (dev_rst) begin
      almost_full_flag_n <= `DCFPC_FLAG_HIGH;
    end else if (a_rise) begin
      almost_full_flag_n <= (fill_a < (FULL_CNT - offset_x));
    end
  end

  // Memory of DEPTH words, read into its own output register
  dcfpc_mem #(
    .WIDTH (WIDTH),
    .AW    (AW)
  ) u_mem (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .wr_en   (fifo_wr),
    .wr_addr (wptr[AW-1:0]),
    .wr_data (data_a_s2),
    .rd_en   (fifo_rd),
    .rd_addr (rptr[AW-1:0]),
    .rd_data (fifo_q)
  );

  // Mail data is kept across reads and across a pin reset
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mail_ab <= '0;
    end else if (mail_ab_wr) begin
      mail_ab <= data_a_s2;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mail_ba <= '0;
    end else if (mail_ba_wr) begin
      mail_ba <= data_b_s2;
    end
  end

  // A new write wins over a read release in the same cycle
  always_ff @(posedge ref_clk) begin
    if (dev_rst) begin
      mail_ab_flag_n <= `DCFPC_FLAG_HIGH;
    end else if (mail_ab_wr) begin
      mail_ab_flag_n <= `DCFPC_FLAG_LOW;
    end else if (mail_ab_rd) begin
      mail_ab_flag_n <= `DCFPC_FLAG_HIGH;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (dev_rst) begin
      mail_ba_flag_n <= `DCFPC_FLAG_HIGH;
    end else if (mail_ba_wr) begin
      mail_ba_flag_n <= `DCFPC_FLAG_LOW;
    end else if (mail_ba_rd) begin
      mail_ba_flag_n <= `DCFPC_FLAG_HIGH;
    end
  end

  // Drive enables follow chip select and write_read pins only, independent of the gate
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      port_a_data_oe <= `DCFPC_FLAG_LOW;
      port_b_data_oe <= `DCFPC_FLAG_LOW;
    end else begin
      port_a_data_oe <= ~ca.chip_sel_n & ~ca.write_read;
      port_b_data_oe <= ~cb.chip_sel_n & ~cb.write_read;
    end
  end

  // Port A only ever shows the B-to-A mail register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      port_a_data_out <= '0;
    end else begin
      port_a_data_out <= mail_ba;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      port_b_data_out <= '0;
    end else begin
      port_b_data_out <= cb.mail_select ? mail_ab : fifo_q;
    end
  end

endmodule : dcfpc_top

// ===== dv/dcfpc_checker.sv
`timescale 1ns/100ps
module dcfpc_checker (
  // Clock and reset
  input wire logic                   ref_clk,
  input wire logic                   sys_rst,
  // Device pins
  input wire logic                   port_a_clock,
  input wire logic                   port_b_clock,
  input wire logic                   reset_n,
  input wire dcfpc_pkg::dcfpc_ctrl_t port_a_ctrl,
  input wire dcfpc_pkg::dcfpc_ctrl_t port_b_ctrl,
  // Outputs under watch
  input wire logic                   port_a_data_oe,
  input wire logic                   port_b_data_oe,
  input wire logic                   full_flag_n,
  input wire logic                   almost_full_flag_n,
  input wire logic                   empty_flag_n,
  input wire logic                   almost_empty_flag_n,
  input wire logic                   mail_ab_flag_n,
  input wire logic                   mail_ba_flag_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // Pin samples hold reset values, chip selects high, just after reset, so hold off the enable checks
  logic [2:0] up;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) up <= 3'h0;
    else if (up != 3'h7) up <= up + 3'h1;
  end

  // Port clock rise seen by the two-stage sampler
  sequence rise_s(c);
    $past(c, 3) && !$past(c, 4);
  endsequence

  oe_a_follow_a: assert property (up == 3'h7 |-> port_a_data_oe ==
    (!$past(port_a_ctrl.chip_sel_n, 3) && !$past(port_a_ctrl.write_read, 3))) else $error("port a enable wrong");
  oe_b_follow_a: assert property (up == 3'h7 |-> port_b_data_oe ==
    (!$past(port_b_ctrl.chip_sel_n, 3) && !$past(port_b_ctrl.write_read, 3))) else $error("port b enable wrong");
  rst_flags_a: assert property (!reset_n [*4] |=> !full_flag_n && !empty_flag_n &&
    !almost_empty_flag_n && almost_full_flag_n) else $error("flags wrong in reset");
  rst_mail_a: assert property (!reset_n [*4] |=> mail_ab_flag_n && mail_ba_flag_n) else $error("mail flags in reset");
  full_rise_a: assert property ($rose(full_flag_n) |-> rise_s(port_a_clock)) else $error("full off port a");
  empty_rise_a: assert property ($rose(empty_flag_n) |-> rise_s(port_b_clock)) else $error("empty off port b");
  afull_sync_a: assert property ($fell(almost_full_flag_n) |-> rise_s(port_a_clock)) else $error("af off port a");
  aempty_sync_a: assert property ($rose(almost_empty_flag_n) |-> rise_s(port_b_clock)) else $error("ae off b");
  mail_ab_set_a: assert property ($fell(mail_ab_flag_n) |->
    $past(port_a_ctrl, 3) == 4'h7 ##0 rise_s(port_a_clock)) else $error("mail ab set wrongly");
  mail_ba_set_a: assert property ($fell(mail_ba_flag_n) |->
    $past(port_b_ctrl, 3) == 4'h7 ##0 rise_s(port_b_clock)) else $error("mail ba set wrongly");

  cover property ($rose(empty_flag_n));
  cover property ($fell(full_flag_n));
  cover property ($fell(mail_ab_flag_n));
endmodule : dcfpc_checker

bind dcfpc_top dcfpc_checker dcfpc_checker_i (.ref_clk, .sys_rst, .port_a_clock, .port_b_clock, .reset_n,
  .port_a_ctrl, .port_b_ctrl, .port_a_data_oe, .port_b_data_oe, .full_flag_n, .almost_full_flag_n,
  .empty_flag_n, .almost_empty_flag_n, .mail_ab_flag_n, .mail_ba_flag_n);

// ===== dv/dcfpc_host.sv
`timescale 1ns/100ps
module dcfpc_host #(
  parameter int HALF_A = 5,
  parameter int HALF_B = 7
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Free-running port clocks
  output logic     port_a_clock,
  output logic     port_b_clock
);
  int cnt_a;
  int cnt_b;

  // Odd start count keeps the two ports out of phase
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt_a <= 0;
      cnt_b <= 3;
      port_a_clock <= 1'b0;
      port_b_clock <= 1'b0;
    end else begin
      cnt_a <= (cnt_a == HALF_A - 1) ? 0 : cnt_a + 1;
      cnt_b <= (cnt_b == HALF_B - 1) ? 0 : cnt_b + 1;
      if (cnt_a == HALF_A - 1) port_a_clock <= ~port_a_clock;
      if (cnt_b == HALF_B - 1) port_b_clock <= ~port_b_clock;
    end
  end
endmodule : dcfpc_host

// ===== dv/dcfpc_bench.sv
`timescale 1ns/100ps
module dcfpc_bench;
  logic                   ref_clk;
  logic                   sys_rst;
  logic                   port_a_clock;
  logic                   port_b_clock;
  logic                   reset_n;
  logic [1:0]             sel;
  dcfpc_pkg::dcfpc_ctrl_t ca;
  dcfpc_pkg::dcfpc_ctrl_t cb;
  logic [35:0]            da;
  logic [35:0]            db;
  logic [35:0]            qa;
  logic [35:0]            qb;
  logic                   oe_a;
  logic                   oe_b;
  logic                   full_flag_n;
  logic                   almost_full_flag_n;
  logic                   empty_flag_n;
  logic                   almost_empty_flag_n;
  logic                   mail_ab_flag_n;
  logic                   mail_ba_flag_n;
  int                     err_total;
  int                     num_checks;

  dcfpc_top dcfpc_top_i (.ref_clk, .sys_rst, .port_a_clock, .port_b_clock, .reset_n, .thresh_sel_0(sel[0]),
    .thresh_sel_1(sel[1]), .port_a_ctrl(ca), .port_b_ctrl(cb), .port_a_data_in(da), .port_a_data_out(qa),
    .port_a_data_oe(oe_a), .port_b_data_in(db), .port_b_data_out(qb), .port_b_data_oe(oe_b), .full_flag_n,
    .almost_full_flag_n, .empty_flag_n, .almost_empty_flag_n, .mail_ab_flag_n, .mail_ba_flag_n);
  dcfpc_host dcfpc_host_i (.ref_clk, .sys_rst, .port_a_clock, .port_b_clock);

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic pwait(input bit b, input logic lv);
    do @(posedge ref_clk); while ((b ? port_b_clock : port_a_clock) !== lv);
  endtask : pwait

  // Controls held from before the rise until the sampler has used them
  task automatic op(input bit b, input logic [3:0] c, input logic [35:0] d);
    pwait(b, 1'b0);
    if (b) begin
      cb <= c;
      db <= d;
    end else begin
      ca <= c;
      da <= d;
    end
    pwait(b, 1'b1);
    repeat (4) @(posedge ref_clk);
    if (b) cb <= 4'h8;
    else ca <= 4'h8;
    if (b) db <= ~d;
    else da <= ~d;
  endtask : op

  task automatic rises(input bit b, input int n);
    repeat (n) begin
      pwait(b, 1'b0);
      pwait(b, 1'b1);
    end
    repeat (4) @(posedge ref_clk);
  endtask : rises

  task automatic dev_reset(input logic [1:0] s);
    sel <= s;
    reset_n <= 1'b0;
    rises(1, 5);
    chk({full_flag_n, empty_flag_n, almost_empty_flag_n, almost_full_flag_n}, 4'h1);
    chk({mail_ab_flag_n, mail_ba_flag_n}, 2'h3);
    reset_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rises(0, 2);
    chk(full_flag_n, 1'b1);
  endtask : dev_reset

  task automatic t_offset;
    int x;
    for (int i = 0; i < 4; i++) begin
      x = 4 + 4 * i;
      dev_reset(i[1:0]);
      for (int j = 0; j < x; j++) op(0, 4'h6, 36'(j));
      rises(1, 3);
      chk(empty_flag_n, 1'b1);
      chk(almost_empty_flag_n, 1'b0);
      op(0, 4'h6, 36'h0ff);
      rises(1, 3);
      chk(almost_empty_flag_n, 1'b1);
    end
  endtask : t_offset

  task automatic t_fill;
    dev_reset(2'h0);
    for (int j = 0; j < 64; j++) op(0, 4'h6, 36'h100 + 36'(j));
    rises(0, 3);
    chk({full_flag_n, almost_full_flag_n}, 2'h0);
    op(0, 4'h6, 36'h0bad);
    for (int j = 0; j < 64; j++) begin
      op(1, 4'h2, 36'h0);
      chk(qb, 36'h100 + 36'(j));
      if (j == 0) rises(0, 3);
      if (j == 0) chk(full_flag_n, 1'b1);
    end
    rises(0, 3);
    chk({empty_flag_n, almost_full_flag_n}, 2'h1);
    op(1, 4'h2, 36'h0);
    chk(qb, 36'h13f);
  endtask : t_fill

  task automatic t_mail;
    op(0, 4'h7, 36'h0a5a5);
    op(0, 4'h7, 36'h0ffff);
    chk(mail_ab_flag_n, 1'b0);
    op(1, 4'h3, 36'h0);
    chk(oe_b, 1'b1);
    chk(qb, 36'h0a5a5);
    chk(mail_ab_flag_n, 1'b1);
    op(1, 4'h7, 36'h5a5a);
    chk(mail_ba_flag_n, 1'b0);
    op(0, 4'h3, 36'h0);
    chk(oe_a, 1'b1);
    chk(qa, 36'h5a5a);
    chk(mail_ba_flag_n, 1'b1);
    repeat (4) @(posedge ref_clk);
    chk({oe_a, oe_b}, 2'h0);
  endtask : t_mail

  task automatic t_gate;
    op(0, 4'h4, 36'h11);
    op(0, 4'h5, 36'h22);
    op(0, 4'h2, 36'h33);
    op(1, 4'h6, 36'h44);
    rises(1, 3);
    chk(empty_flag_n, 1'b0);
    chk(mail_ab_flag_n, 1'b1);
  endtask : t_gate

  task automatic results;
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results

  initial begin
    repeat (40000) @(posedge ref_clk);
    err_total++;
    results();
  end

  initial begin
    err_total = 0;
    num_checks = 0;
    sys_rst = 1'b1;
    reset_n = 1'b0;
    sel = 2'h0;
    ca = 4'h8;
    cb = 4'h8;
    da = 36'h0;
    db = 36'h0;
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_offset();
    t_fill();
    t_mail();
    t_gate();
    results();
  end
endmodule : dcfpc_bench
